// ---- rtl/eps_assoc_top.sv ----
// enable-pin supply association block with axi4-lite register access
`timescale 1ns/1ps
`include "eps_assoc_cfg.svh"
// ****************************************************************
// Contract
// - fet rail on pin one: pin high uses operating, low reduced
// - association bit clear: pin ignored, supply follows programming
// - core converter on pin one: operating when high, reduced when low
// - core on pin one, pin low, keep set: low-power unless off
// - io converter on pin one: on when high, else off or low-power
// - pin two regulator bits 7..0 map regulators 3,4,7,8,5,2,1,6
// - pin two low: regulator off if keep clear, low-power if set
// - fet rail on pin two: op/reduced select, keep gives low-power
// - core on pin two: operating when high, reduced incl off when low
// - core on pin two, pin low, keep set: low-power unless off
// - io converter on pin two: on when high, else off or low-power
// - association registers cleared only by the turn-off reset
// - any pin one association bit except spare switcher bit 4 disables the voltage-scaling port
// - keep register holds core b, core a and io keep bits
// ****************************************************************
module eps_assoc_top
(
	// clock and resets
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        turnoff_reset_n,
	// enable pins
	input  wire logic        enable_pin_one,
	input  wire logic        enable_pin_two,
	// programmed state from the device sequencer
	input  wire logic [7:0]  prog_sw_mode,
	input  wire logic [31:0] prog_sw_volt,
	input  wire logic [15:0] prog_lin_mode,
	// axi4-lite write
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// supply controls
	output logic [7:0]       sw_mode,
	output logic [31:0]      sw_volt,
	output logic [15:0]      lin_mode,
	output logic             dvs_if_disable
);
	import eps_assoc_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [1:0]   pin_sync;
	logic         awready_ff;
	logic         wready_ff;
	logic         bvalid_ff;
	logic [1:0]   bresp_ff;
	logic         arready_ff;
	logic         rvalid_ff;
	logic [1:0]   rresp_ff;
	logic [31:0]  rdata_ff;
	logic         aw_got_ff;
	logic         w_got_ff;
	logic [9:0]   waddr_ff;
	logic [7:0]   wbyte_ff;
	logic         wlane_ff;
	logic [7:0]   one_lin_ff;
	logic [7:0]   one_sw_ff;
	logic [7:0]   two_lin_ff;
	logic [7:0]   two_sw_ff;
	logic [7:0]   sw_keep_ff;
	logic [7:0]   lin_keep_ff;
	logic [7:0]   fet_keep_ff;
	logic [7:0]   volt_ff [0:5];
	logic [7:0]   sw_mode_ff;
	logic [31:0]  sw_volt_ff;
	logic [15:0]  lin_mode_ff;
	logic         dvs_off_ff;
	logic         aw_take;
	logic         w_take;
	logic         ar_take;
	logic         do_write;
	logic         nxt_aw_got;
	logic         nxt_w_got;
	logic         nxt_bvalid;
	logic         nxt_rvalid;
	logic [9:0]   rd_idx;
	logic [31:0]  nxt_rdata;
	logic         rd_hit;
	logic         wr_hit;
	logic [3:0]   keep_sw;
	eps_mode_type nxt_sw [0:3];
	logic [7:0]   nxt_volt [0:3];
	eps_mode_type nxt_lin [0:7];

	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	eps_pin_sync u_sync
	(
		.clock    (clock),
		.reset_n  (reset_n),
		.pin_raw  ({enable_pin_two, enable_pin_one}),
		.pin_sync (pin_sync)
	);

	// ****************************************************************
	// axi4-lite handshakes
	// ****************************************************************
	always_comb
	begin
		aw_take    = s_axi_awvalid & awready_ff;
		w_take     = s_axi_wvalid & wready_ff;
		ar_take    = s_axi_arvalid & arready_ff;
		do_write   = aw_got_ff & w_got_ff;
		nxt_aw_got = ~do_write & (aw_got_ff | aw_take);
		nxt_w_got  = ~do_write & (w_got_ff | w_take);
		nxt_bvalid = do_write | (bvalid_ff & ~s_axi_bready);
		nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
		wr_hit     = (waddr_ff == `EPS_IDX_LIN_KEEP) |
			(waddr_ff == `EPS_IDX_SW_KEEP) |
			(waddr_ff == `EPS_IDX_ONE_LIN) |
			(waddr_ff == `EPS_IDX_ONE_SW) |
			(waddr_ff == `EPS_IDX_TWO_LIN) |
			(waddr_ff == `EPS_IDX_TWO_SW) |
			(waddr_ff == `EPS_IDX_FET_KEEP) |
			((waddr_ff >= `EPS_IDX_VOLT_BASE) &
			(waddr_ff <= `EPS_IDX_VOLT_LAST));
	end

	// one write and one read outstanding; readies drop while busy
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= `EPS_RESP_OKAY;
			waddr_ff   <= 10'h000;
			wbyte_ff   <= 8'h00;
			wlane_ff   <= 1'b0;
		end
		else
		begin
			awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
			aw_got_ff  <= nxt_aw_got;
			w_got_ff   <= nxt_w_got;
			bvalid_ff  <= nxt_bvalid;
			if (aw_take)
			begin
				waddr_ff <= s_axi_awaddr[11:2];
			end
			if (w_take)
			begin
				wbyte_ff <= s_axi_wdata[7:0];
				wlane_ff <= s_axi_wstrb[0];
			end
			if (do_write)
			begin
				bresp_ff <= wr_hit ? `EPS_RESP_OKAY : `EPS_RESP_SLVERR;
			end
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	always_comb
	begin
		rd_idx    = s_axi_araddr[11:2];
		rd_hit    = 1'b1;
		nxt_rdata = 32'h0000_0000;
		case (rd_idx)
			`EPS_IDX_LIN_KEEP: nxt_rdata[7:0] = lin_keep_ff;
			`EPS_IDX_SW_KEEP:  nxt_rdata[7:0] = sw_keep_ff;
			`EPS_IDX_ONE_LIN:  nxt_rdata[7:0] = one_lin_ff;
			`EPS_IDX_ONE_SW:   nxt_rdata[7:0] = one_sw_ff;
			`EPS_IDX_TWO_LIN:  nxt_rdata[7:0] = two_lin_ff;
			`EPS_IDX_TWO_SW:   nxt_rdata[7:0] = two_sw_ff;
			`EPS_IDX_FET_KEEP: nxt_rdata[7:0] = fet_keep_ff;
			default:
			begin
				if ((rd_idx >= `EPS_IDX_VOLT_BASE) &&
					(rd_idx <= `EPS_IDX_VOLT_LAST))
				begin
					nxt_rdata[7:0] =
						volt_ff[3'(rd_idx - `EPS_IDX_VOLT_BASE)];
				end
				else
				begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= `EPS_RESP_OKAY;
			rdata_ff   <= 32'h0000_0000;
		end
		else
		begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_take)
			begin
				rdata_ff <= nxt_rdata;
				rresp_ff <= rd_hit ? `EPS_RESP_OKAY : `EPS_RESP_SLVERR;
			end
		end
	end

	// ****************************************************************
	// association registers, turn-off reset only
	// ****************************************************************
	// a general reset must not lose which pin drives which supply
	always_ff @(posedge clock or negedge turnoff_reset_n)
	begin
		if (!turnoff_reset_n)
		begin
			one_lin_ff <= `EPS_RESET_BYTE;
			one_sw_ff  <= `EPS_RESET_BYTE;
			two_lin_ff <= `EPS_RESET_BYTE;
			two_sw_ff  <= `EPS_RESET_BYTE;
		end
		else if (do_write & wlane_ff)
		begin
			if (waddr_ff == `EPS_IDX_ONE_LIN)
			begin
				one_lin_ff <= wbyte_ff;
			end
			if (waddr_ff == `EPS_IDX_ONE_SW)
			begin
				one_sw_ff <= wbyte_ff & `EPS_SW_ASSOC_MASK;
			end
			if (waddr_ff == `EPS_IDX_TWO_LIN)
			begin
				two_lin_ff <= wbyte_ff;
			end
			if (waddr_ff == `EPS_IDX_TWO_SW)
			begin
				two_sw_ff <= wbyte_ff & `EPS_SW_ASSOC_MASK;
			end
		end
	end

	// ****************************************************************
	// keep and voltage registers, general reset
	// ****************************************************************
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sw_keep_ff  <= `EPS_RESET_BYTE;
			lin_keep_ff <= `EPS_RESET_BYTE;
			fet_keep_ff <= `EPS_RESET_BYTE;
		end
		else if (do_write & wlane_ff)
		begin
			if (waddr_ff == `EPS_IDX_SW_KEEP)
			begin
				sw_keep_ff <= wbyte_ff & `EPS_SW_KEEP_MASK;
			end
			if (waddr_ff == `EPS_IDX_LIN_KEEP)
			begin
				lin_keep_ff <= wbyte_ff;
			end
			if (waddr_ff == `EPS_IDX_FET_KEEP)
			begin
				fet_keep_ff <= wbyte_ff & `EPS_FET_KEEP_MASK;
			end
		end
	end

	for (genvar v = 0; v < 6; v++)
	begin : g_volt
		always_ff @(posedge clock or negedge reset_n)
		begin
			if (!reset_n)
			begin
				volt_ff[v] <= `EPS_VOLT_OFF;
			end
			else if (do_write & wlane_ff &
				(waddr_ff == `EPS_IDX_VOLT_BASE + 10'(v)))
			begin
				volt_ff[v] <= wbyte_ff;
			end
		end
	end

	// ****************************************************************
	// switcher selection
	// ****************************************************************
	assign keep_sw = {fet_keep_ff[0], sw_keep_ff[2:0]};

	// spare bit 4 is never routed, so it cannot steer a supply
	for (genvar i = 0; i < 4; i++)
	begin : g_sw
		logic [7:0] op_v;
		logic [7:0] red_v;
		if (i == `EPS_SW_IO)
		begin : g_io
			assign op_v  = prog_sw_volt[7:0];
			assign red_v = prog_sw_volt[7:0];
		end
		else
		begin : g_reg
			assign op_v  = volt_ff[2 * (i - 1)];
			assign red_v = volt_ff[2 * (i - 1) + 1];
		end
		eps_supply_sel u_sel
		(
			.assoc_one (one_sw_ff[i]),
			.assoc_two (two_sw_ff[i]),
			.pin_one   (pin_sync[0]),
			.pin_two   (pin_sync[1]),
			.keep      (keep_sw[i]),
			.io_rail   (i == `EPS_SW_IO),
			.op_volt   (op_v),
			.red_volt  (red_v),
			.prog_mode (eps_mode_type'(prog_sw_mode[2 * i +: 2])),
			.prog_volt (prog_sw_volt[8 * i +: 8]),
			.mode      (nxt_sw[i]),
			.volt      (nxt_volt[i])
		);
	end

	// ****************************************************************
	// linear regulator selection
	// ****************************************************************
	for (genvar b = 0; b < 8; b++)
	begin : g_lin
		localparam int N = eps_lin_of_bit[b] - 1;
		logic pin;
		assign pin = one_lin_ff[b] ? pin_sync[0] : pin_sync[1];
		assign nxt_lin[N] = !(one_lin_ff[b] | two_lin_ff[b]) ?
			eps_mode_type'(prog_lin_mode[2 * N +: 2]) :
			pin ? eps_full : lin_keep_ff[b] ? eps_low : eps_off;
	end

	// ****************************************************************
	// output registers
	// ****************************************************************
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sw_mode_ff  <= 8'h00;
			sw_volt_ff  <= 32'h0000_0000;
			lin_mode_ff <= 16'h0000;
			dvs_off_ff  <= 1'b0;
		end
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				sw_mode_ff[2 * k +: 2] <= nxt_sw[k];
				sw_volt_ff[8 * k +: 8] <= nxt_volt[k];
			end
			for (int k = 0; k < 8; k++)
			begin
				lin_mode_ff[2 * k +: 2] <= nxt_lin[k];
			end
			dvs_off_ff <= |{one_lin_ff, one_sw_ff[3:0]};
		end
	end

	assign s_axi_awready  = awready_ff;
	assign s_axi_wready   = wready_ff;
	assign s_axi_bvalid   = bvalid_ff;
	assign s_axi_bresp    = bresp_ff;
	assign s_axi_arready  = arready_ff;
	assign s_axi_rvalid   = rvalid_ff;
	assign s_axi_rresp    = rresp_ff;
	assign s_axi_rdata    = rdata_ff;
	assign sw_mode        = sw_mode_ff;
	assign sw_volt        = sw_volt_ff;
	assign lin_mode       = lin_mode_ff;
	assign dvs_if_disable = dvs_off_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	property p_fet_one;
		one_sw_ff[3] && pin_sync[0] && volt_ff[4] != 8'h00 |=>
			sw_mode[7:6] == eps_full && sw_volt[31:24] == $past(volt_ff[4]);
	endproperty
	a_fet_one: assert property (p_fet_one)
		else $error("fet rail ignores operating voltage on pin one");

	property p_no_assoc;
		!one_sw_ff[1] && !two_sw_ff[1] |=>
			sw_mode[3:2] == $past(prog_sw_mode[3:2]) &&
			sw_volt[15:8] == $past(prog_sw_volt[15:8]);
	endproperty
	a_no_assoc: assert property (p_no_assoc)
		else $error("unassociated core a does not follow programming");

	property p_core_red;
		one_sw_ff[2] && !pin_sync[0] |=>
			sw_volt[23:16] == $past(volt_ff[3]);
	endproperty
	a_core_red: assert property (p_core_red)
		else $error("core b not on reduced voltage with pin one low");

	property p_core_low;
		one_sw_ff[1] && !pin_sync[0] && sw_keep_ff[1] &&
			volt_ff[1] != 8'h00 |=> sw_mode[3:2] == eps_low;
	endproperty
	a_core_low: assert property (p_core_low)
		else $error("core a not in low-power mode with keep set");

	// association and pin are sampled in the same cycle the output uses
	property p_io_one;
		one_sw_ff[0] && pin_sync[0] |=> sw_mode[1:0] == eps_full;
	endproperty
	a_io_one: assert property (p_io_one)
		else $error("io converter not on with pin one high");

	property p_lin_two;
		two_lin_ff[7] && !one_lin_ff[7] && pin_sync[1] |=>
			lin_mode[5:4] == eps_full;
	endproperty
	a_lin_two: assert property (p_lin_two)
		else $error("regulator three not on with pin two high");

	property p_lin_sleep;
		two_lin_ff[0] && !one_lin_ff[0] && !pin_sync[1] &&
			!lin_keep_ff[0] |=> lin_mode[11:10] == eps_off;
	endproperty
	a_lin_sleep: assert property (p_lin_sleep)
		else $error("regulator six not off with pin two low");

	property p_fet_two;
		two_sw_ff[3] && !one_sw_ff[3] && !pin_sync[1] && fet_keep_ff[0] &&
			volt_ff[5] != 8'h00 |=> sw_mode[7:6] == eps_low;
	endproperty
	a_fet_two: assert property (p_fet_two)
		else $error("fet rail not low-power with pin two low");

	property p_assoc_hold;
		@(posedge clock) disable iff (!turnoff_reset_n)
		!reset_n |=> $stable(two_sw_ff) && $stable(two_lin_ff);
	endproperty
	a_assoc_hold: assert property (p_assoc_hold)
		else $error("association lost on general reset");

	property p_dvs;
		1'b1 |=> dvs_if_disable == $past(|{one_lin_ff, one_sw_ff[3:0]});
	endproperty
	a_dvs: assert property (p_dvs)
		else $error("voltage-scaling disable does not track pin one bits");

	property p_sync;
		$past(reset_n, 2) |-> pin_sync[1] == $past(enable_pin_two, 2);
	endproperty
	a_sync: assert property (p_sync)
		else $error("pin two not delayed by two synchroniser stages");

	c_io_low: cover property (one_sw_ff[0] ##1 sw_mode[1:0] == eps_low);
	c_lin_off: cover property (two_lin_ff != 8'h00 ##1 lin_mode == 16'h0);
	c_write: cover property (bvalid_ff && s_axi_bready);
endmodule // eps_assoc_top

// ---- rtl/eps_assoc_cfg.svh ----
// register indices, field positions and reset values of the pin association block
`ifndef EPS_ASSOC_CFG_SVH
`define EPS_ASSOC_CFG_SVH

// register indices; byte address is four times the index
`define EPS_IDX_LIN_KEEP   10'h041
`define EPS_IDX_SW_KEEP    10'h042
`define EPS_IDX_ONE_LIN    10'h045
`define EPS_IDX_ONE_SW     10'h046
`define EPS_IDX_TWO_LIN    10'h047
`define EPS_IDX_TWO_SW     10'h048
`define EPS_IDX_FET_KEEP   10'h04a
`define EPS_IDX_VOLT_BASE  10'h020
`define EPS_IDX_VOLT_LAST  10'h025

// writable bits of each register
`define EPS_SW_ASSOC_MASK  8'h1f
`define EPS_SW_KEEP_MASK   8'hf7
`define EPS_FET_KEEP_MASK  8'h01

// switcher field positions in the association registers and, except fet, the keep register
`define EPS_SW_IO          0
`define EPS_SW_CORE_A      1
`define EPS_SW_CORE_B      2
`define EPS_SW_FET         3

// reset values and codes
`define EPS_RESET_BYTE     8'h00
`define EPS_VOLT_OFF       8'h00
`define EPS_RESP_OKAY      2'b00
`define EPS_RESP_SLVERR    2'b10

`endif

// ---- rtl/eps_assoc_pkg.sv ----
// types shared by the pin association block
package eps_assoc_pkg;

	// supply operating mode driven to the converters
	typedef enum logic [1:0]
	{
		eps_off  = 2'h0,
		eps_full = 2'h1,
		eps_low  = 2'h3
	} eps_mode_type;

	// linear regulator number held by each bit of a regulator register
	localparam int eps_lin_of_bit [0:7] = '{6, 1, 2, 5, 8, 7, 4, 3};

endpackage

// ---- rtl/eps_pin_sync.sv ----
// two-flop synchroniser for the two enable pins
`timescale 1ns/1ps
module eps_pin_sync
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// pins and synchronised levels
	input  wire logic [1:0] pin_raw,
	output logic      [1:0] pin_sync
);
	logic [1:0] meta_ff;
	logic [1:0] hold_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_ff <= 2'h0;
			hold_ff <= 2'h0;
		end
		else
		begin
			meta_ff <= pin_raw;
			hold_ff <= meta_ff;
		end
	end

	assign pin_sync = hold_ff;
endmodule // eps_pin_sync

// ---- rtl/eps_supply_sel.sv ----
// one switcher: chooses pin-driven or programmed mode and voltage
`timescale 1ns/1ps
`include "eps_assoc_cfg.svh"
module eps_supply_sel
(
	// association and synchronised pins
	input  wire logic                        assoc_one,
	input  wire logic                        assoc_two,
	input  wire logic                        pin_one,
	input  wire logic                        pin_two,
	// settings
	input  wire logic                        keep,
	input  wire logic                        io_rail,
	input  wire logic [7:0]                  op_volt,
	input  wire logic [7:0]                  red_volt,
	input  wire eps_assoc_pkg::eps_mode_type prog_mode,
	input  wire logic [7:0]                  prog_volt,
	// result
	output eps_assoc_pkg::eps_mode_type      mode,
	output logic [7:0]                       volt
);
	import eps_assoc_pkg::*;

	logic       pin;
	logic [7:0] sel;

	always_comb
	begin
		// pin one wins when both pins are associated
		pin  = assoc_one ? pin_one : pin_two;
		sel  = pin ? op_volt : red_volt;
		mode = prog_mode;
		volt = prog_volt;
		if (assoc_one | assoc_two)
		begin
			if (io_rail)
			begin
				mode = pin ? eps_full : (keep ? eps_low : eps_off);
			end
			else
			begin
				volt = sel;
				if (sel == `EPS_VOLT_OFF)
				begin
					mode = eps_off;
				end
				else if (pin | !keep)
				begin
					mode = eps_full;
				end
				else
				begin
					mode = eps_low;
				end
			end
		end
	end
endmodule // eps_supply_sel

// ---- verification/eps_host_pins.sv ----
// host-side model that drives the two enable pins
`timescale 1ns/1ps
module eps_host_pins
(
	// clock
	input  wire logic clock,
	// levels asked for by the bench
	input  wire logic level_one,
	input  wire logic level_two,
	// enable pins
	output logic      enable_pin_one,
	output logic      enable_pin_two
);
	// pins start low so the block never sees an unknown level
	initial
	begin
		enable_pin_one = 1'b0;
		enable_pin_two = 1'b0;
	end
	// a host gpio update lands on a rising clock edge, in step with the block clock
	always @(posedge clock)
	begin
		enable_pin_one <= level_one;
		enable_pin_two <= level_two;
	end
endmodule // eps_host_pins

// ---- verification/tb.sv ----
// self-checking bench for the pin association block
`timescale 1ns/1ps
`include "eps_assoc_cfg.svh"
module tb;
	import eps_assoc_pkg::*;
	logic        clock = 1'b0, reset_n = 1'b0, turnoff_reset_n = 1'b0;
	logic        level_one = 1'b0, level_two = 1'b0;
	logic        enable_pin_one, enable_pin_two;
	logic [7:0]  prog_sw_mode = 8'h00;
	logic [31:0] prog_sw_volt = 32'h0;
	logic [15:0] prog_lin_mode = 16'h0;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [7:0]  sw_mode;
	logic [31:0] sw_volt;
	logic [15:0] lin_mode;
	logic        dvs_if_disable;
	int          err_count = 0, cmp_count = 0;
	logic [7:0]  sh [0:12];
	localparam logic [9:0] idx_tab [0:12] = '{`EPS_IDX_LIN_KEEP,
		`EPS_IDX_SW_KEEP, `EPS_IDX_ONE_LIN, `EPS_IDX_ONE_SW, `EPS_IDX_TWO_LIN,
		`EPS_IDX_TWO_SW, `EPS_IDX_FET_KEEP, 10'h020, 10'h021, 10'h022,
		10'h023, 10'h024, 10'h025};
	localparam logic [7:0] msk_tab [0:12] = '{8'hff, `EPS_SW_KEEP_MASK,
		8'hff, `EPS_SW_ASSOC_MASK, 8'hff, `EPS_SW_ASSOC_MASK,
		`EPS_FET_KEEP_MASK, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
	localparam int lin_tab [0:7] = '{6, 1, 2, 5, 8, 7, 4, 3};

	always #25 clock = ~clock;

	eps_host_pins host (.clock(clock), .level_one(level_one),
		.level_two(level_two), .enable_pin_one(enable_pin_one),
		.enable_pin_two(enable_pin_two));

	eps_assoc_top dut (.clock(clock), .reset_n(reset_n),
		.turnoff_reset_n(turnoff_reset_n), .enable_pin_one(enable_pin_one),
		.enable_pin_two(enable_pin_two), .prog_sw_mode(prog_sw_mode),
		.prog_sw_volt(prog_sw_volt), .prog_lin_mode(prog_lin_mode),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .sw_mode(sw_mode),
		.sw_volt(sw_volt), .lin_mode(lin_mode),
		.dvs_if_disable(dvs_if_disable));

	// ****************************************************************
	// bus tasks
	// ****************************************************************
	task automatic report_and_stop();
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got,
		input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (n > 40)
			begin
				err_count++;
				report_and_stop();
			end
		end
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (n > 40)
			begin
				err_count++;
				report_and_stop();
			end
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wreg(input int p, input logic [7:0] d);
		logic [1:0] r;
		wr({idx_tab[p], 2'b00}, d, 4'h1, r);
		chk("bresp", r, `EPS_RESP_OKAY);
		sh[p] = d & msk_tab[p];
	endtask

	task automatic check_regs(input int lo, input int hi);
		logic [31:0] d;
		logic [1:0]  r;
		for (int p = lo; p <= hi; p++)
		begin
			rd({idx_tab[p], 2'b00}, d, r);
			chk("reg_value", d, {24'h0, sh[p]});
			chk("rresp", r, `EPS_RESP_OKAY);
		end
	endtask

	task automatic check_outputs();
		logic [1:0] pm;
		logic [7:0] pv;
		logic       pin, kp, dv;
		for (int i = 0; i < 4; i++)
		begin
			pm = prog_sw_mode[2*i+:2];
			pv = prog_sw_volt[8*i+:8];
			pin = sh[3][i] ? enable_pin_one : enable_pin_two;
			kp = (i == 3) ? sh[6][0] : sh[1][i];
			if (i == 0 && (sh[3][0] | sh[5][0]))
				pm = pin ? 2'h1 : (kp ? 2'h3 : 2'h0);
			else if (i != 0 && (sh[3][i] | sh[5][i]))
			begin
				pv = pin ? sh[5+2*i] : sh[6+2*i];
				pm = (pv == 8'h00) ? 2'h0 : ((!pin && kp) ? 2'h3 : 2'h1);
			end
			chk("sw_mode", sw_mode[2*i+:2], pm);
			// an off supply is judged only by the line above
			if (pm != 2'h0)
				chk("sw_volt", sw_volt[8*i+:8], pv);
		end
		for (int b = 0; b < 8; b++)
		begin
			pin = sh[2][b] ? enable_pin_one : enable_pin_two;
			pm = prog_lin_mode[2*(lin_tab[b]-1)+:2];
			if (sh[2][b] | sh[4][b])
				pm = pin ? 2'h1 : (sh[0][b] ? 2'h3 : 2'h0);
			chk("lin_mode", lin_mode[2*(lin_tab[b]-1)+:2], pm);
		end
		dv = (|sh[2]) | (|sh[3][3:0]);
		chk("dvs_if_disable", dvs_if_disable, dv);
	endtask

	function automatic logic [1:0] legal_mode();
		int v;
		v = $urandom % 3;
		return (v == 2) ? 2'h3 : 2'(v);
	endfunction

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		void'($urandom(32'h1ed9ad89));
		repeat (3) @(posedge clock);
		chk("reset_out", {sw_mode, lin_mode, 7'h0, dvs_if_disable}, 32'h0);
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		turnoff_reset_n <= 1'b1;
		for (int p = 0; p < 13; p++)
			sh[p] = `EPS_RESET_BYTE;
		check_regs(0, 12);
		// unmapped place and a write with no byte lane enabled
		rd(12'hffc, d, r);
		chk("unmapped_rdata", d, 32'h0);
		chk("unmapped_rresp", r, `EPS_RESP_SLVERR);
		wr(12'hffc, 8'h5a, 4'h1, r);
		chk("unmapped_bresp", r, `EPS_RESP_SLVERR);
		wr({`EPS_IDX_TWO_SW, 2'b00}, 8'h0f, 4'h0, r);
		chk("nolane_bresp", r, `EPS_RESP_OKAY);
		check_regs(5, 5);
		// io rail on pin one: two sync stages then the output register
		wreg(3, 8'h01);
		repeat (6) @(posedge clock);
		level_one <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk("sync_hold", sw_mode[1:0], 2'h0);
		@(posedge clock);
		#1 chk("sync_pass", sw_mode[1:0], 2'h1);
		for (int it = 0; it < 30; it++)
		begin
			for (int p = 0; p < 13; p++)
				wreg(p, ($urandom % 4 == 0) ? 8'h00 : 8'($urandom));
			for (int k = 0; k < 8; k++)
				prog_lin_mode[2*k+:2] <= legal_mode();
			for (int k = 0; k < 4; k++)
				prog_sw_mode[2*k+:2] <= legal_mode();
			prog_sw_volt <= $urandom;
			for (int q = 0; q < 4; q++)
			begin
				level_one <= q[0];
				level_two <= q[1];
				repeat (6) @(posedge clock);
				check_outputs();
			end
			check_regs(0, 12);
		end
		// general reset keeps associations, turn-off reset clears them
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		// keep and voltage registers clear, associations survive
		for (int p = 0; p < 13; p++)
			if (p < 2 || p > 5)
				sh[p] = `EPS_RESET_BYTE;
		check_regs(0, 12);
		@(posedge clock);
		turnoff_reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		turnoff_reset_n <= 1'b1;
		for (int p = 2; p < 6; p++)
			sh[p] = `EPS_RESET_BYTE;
		check_regs(2, 5);
		report_and_stop();
	end
endmodule // tb
